// ===== hdl/adcc_regs.vh
// Purpose: register map, field positions and timing counts of the conversion control
// Assumes: 32-bit APB, one aligned word per register
// Notes: included by adcc_top.v
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH
`define ADCC_CSR_OFF 12'h000
`define ADCC_RESH_OFF 12'h004
`define ADCC_RESL_OFF 12'h008
`define ADCC_IRQ_STAT_OFF 12'h00C
`define ADCC_IRQ_MASK_OFF 12'h010
`define ADCC_PORT_OFF 12'h014
`define ADCC_MODE_OFF 12'h018
`define ADCC_CSR_CH_LSB 0
`define ADCC_CSR_CH_MSB 3
`define ADCC_CSR_ON_BIT 5
`define ADCC_CSR_DONE_BIT 7
`define ADCC_MODE_WAIT_BIT 0
`define ADCC_MODE_HALT_BIT 1
`define ADCC_MODE_STAB_BIT 2
`define ADCC_CSR_RESET 8'h00
`define ADCC_RES_FULL 10'h3FF
`define ADCC_RES_ZERO 10'h000
`define ADCC_CONV_CYCLES 16
`define ADCC_STAB_CYCLES 64
`endif

// ===== hdl/adcc_top.v
// Purpose: control of a 10-bit continuously converting analog-to-digital converter
// Assumes: pclk 125 MHz, presetn asynchronous active low, APB slave, analog front end
//    delivers a 10-bit code plus over/under range flags for the selected channel
// Notes: one event (conversion done) feeds the sticky interrupt status
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "adcc_regs.vh"
module adcc_top #(
   parameter CONV_CYCLES = `ADCC_CONV_CYCLES,
   parameter STAB_CYCLES = `ADCC_STAB_CYCLES,
   parameter PORT_WIDTH = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [9:0] analog_code,
   input wire analog_over,
   input wire analog_under,
   input wire [PORT_WIDTH-1:0] port_pins,
   input wire halt_req,
   input wire wait_req,
   output reg [3:0] channel_select_field,
   output reg converter_power,
   output reg sample_start,
   output reg irq
);

// ----------------------------------------
// state and registers
// ----------------------------------------
localparam ST_OFF = 3'b001;
localparam ST_CONV = 3'b010;
localparam ST_HALT = 3'b100;

reg [2:0] state;
reg [2:0] next_state;
reg converter_on;
reg done_flag;
reg [7:0] result_high_reg;
reg [1:0] result_low_reg;
reg [15:0] conv_cnt;
reg [15:0] stab_cnt;
reg irq_stat;
reg irq_mask;
reg wait_seen;

wire wr_acc = psel & penable & pwrite;
wire rd_acc = psel & penable & ~pwrite;
wire csr_wr = wr_acc & (paddr == `ADCC_CSR_OFF);
wire [3:0] new_ch = pwdata[`ADCC_CSR_CH_MSB:`ADCC_CSR_CH_LSB];
wire new_on = pwdata[`ADCC_CSR_ON_BIT];
wire ch_change = csr_wr & (new_ch != channel_select_field);
wire on_rise = csr_wr & new_on & ~converter_on;
wire conv_end = (state == ST_CONV) & (conv_cnt == CONV_CYCLES[15:0] - 16'h0001) & ~ch_change;
wire rd_high = rd_acc & (paddr == `ADCC_RESH_OFF);
reg [9:0] code;

// clamp above range, clamp below range
always @* begin
   if (analog_over) begin
      code = `ADCC_RES_FULL;
   end else if (analog_under) begin
      code = `ADCC_RES_ZERO;
   end else begin
      code = analog_code;
   end
end

// ----------------------------------------
// conversion sequencer
// ----------------------------------------
always @* begin
   next_state = state;
   case (state)
      ST_OFF: begin
         if (halt_req) begin
            next_state = ST_HALT;
         end else if (on_rise) begin
            next_state = ST_CONV;
         end
      end
      ST_CONV: begin
         // off stops, halt disables; wait_req deliberately ignored
         if (halt_req) begin
            next_state = ST_HALT;
         end else if (csr_wr & ~new_on) begin
            next_state = ST_OFF;
         end
      end
      ST_HALT: begin
         if (!halt_req) begin
            // a write in the wakeup cycle decides, or the sequencer would stall
            next_state = (csr_wr ? new_on : converter_on) ? ST_CONV : ST_OFF;
         end
      end
      default: begin
         next_state = ST_OFF;
      end
   endcase
end

// ----------------------------------------
// channel and enable register
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      converter_on <= 1'b0;
      channel_select_field <= 4'h0;
   end else if (csr_wr) begin
      channel_select_field <= new_ch;
      converter_on <= new_on;
   end
end

// ----------------------------------------
// sequencer state
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      state <= ST_OFF;
   end else begin
      state <= next_state;
   end
end

// ----------------------------------------
// conversion timing
// ----------------------------------------
reg conv_restart;
reg [15:0] next_conv_cnt;
reg next_sample_start;
reg next_converter_power;

always @* begin
   conv_restart = (state != ST_CONV) | conv_end | ch_change;
   next_converter_power = (next_state == ST_CONV);
   next_sample_start = next_converter_power & conv_restart;
   if (!next_converter_power || conv_restart) begin
      next_conv_cnt = 16'h0000;
   end else begin
      next_conv_cnt = conv_cnt + 16'h0001;
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      conv_cnt <= 16'h0000;
      converter_power <= 1'b0;
      sample_start <= 1'b0;
   end else begin
      conv_cnt <= next_conv_cnt;
      converter_power <= next_converter_power;
      sample_start <= next_sample_start;
   end
end

// ----------------------------------------
// low power modes
// ----------------------------------------
reg [15:0] next_stab_cnt;

always @* begin
   if (state == ST_HALT) begin
      next_stab_cnt = STAB_CYCLES[15:0];
   end else if (stab_cnt != 16'h0000) begin
      next_stab_cnt = stab_cnt - 16'h0001;
   end else begin
      next_stab_cnt = stab_cnt;
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      stab_cnt <= 16'h0000;
      wait_seen <= 1'b0;
   end else begin
      stab_cnt <= next_stab_cnt;
      wait_seen <= wait_req;
   end
end

// ----------------------------------------
// results and done flag
// ----------------------------------------
reg next_done_flag;

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      result_high_reg <= 8'h00;
      result_low_reg <= 2'h0;
   end else if (conv_end) begin
      result_high_reg <= code[9:2];
      result_low_reg <= code[1:0];
   end
end

// set wins over the read clear in one cycle; a channel change blocks the set and clears
always @* begin
   if (conv_end) begin
      next_done_flag = 1'b1;
   end else if (ch_change) begin
      next_done_flag = 1'b0;
   end else if (rd_high) begin
      next_done_flag = 1'b0;
   end else begin
      next_done_flag = done_flag;
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      done_flag <= 1'b0;
   end else begin
      done_flag <= next_done_flag;
   end
end

// ----------------------------------------
// interrupt status, mask and output
// ----------------------------------------
wire stat_wr = wr_acc & (paddr == `ADCC_IRQ_STAT_OFF);
wire mask_wr = wr_acc & (paddr == `ADCC_IRQ_MASK_OFF);
reg next_irq_stat;
reg next_irq_mask;

// the write-one clear loses to a new done event
always @* begin
   if (conv_end) begin
      next_irq_stat = 1'b1;
   end else if (stat_wr & pwdata[0]) begin
      next_irq_stat = 1'b0;
   end else begin
      next_irq_stat = irq_stat;
   end
   if (mask_wr) begin
      next_irq_mask = pwdata[0];
   end else begin
      next_irq_mask = irq_mask;
   end
end

// built from next values so irq never lags status or mask
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      irq_stat <= 1'b0;
      irq_mask <= 1'b0;
      irq <= 1'b0;
   end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq_stat & next_irq_mask;
   end
end

// ----------------------------------------
// apb slave, zero wait states
// ----------------------------------------
wire setup_phase = psel & ~penable;
reg [31:0] next_prdata;
reg next_pslverr;

// data fetched in setup so it stands through the access cycle
always @* begin
   next_prdata = 32'h00000000;
   next_pslverr = 1'b0;
   if (setup_phase) begin
      case (paddr)
         `ADCC_CSR_OFF: begin
            next_prdata = {24'h000000, done_flag, 1'b0, converter_on, 1'b0,
               channel_select_field};
         end
         `ADCC_RESH_OFF: begin
            next_prdata = {24'h000000, result_high_reg};
         end
         `ADCC_RESL_OFF: begin
            next_prdata = {30'h00000000, result_low_reg};
         end
         `ADCC_IRQ_STAT_OFF: begin
            next_prdata = {31'h00000000, irq_stat};
         end
         `ADCC_IRQ_MASK_OFF: begin
            next_prdata = {31'h00000000, irq_mask};
         end
         `ADCC_PORT_OFF: begin
            next_prdata = {{(32-PORT_WIDTH){1'b0}}, port_pins};
         end
         `ADCC_MODE_OFF: begin
            next_prdata = {29'h00000000, (stab_cnt != 16'h0000),
               (state == ST_HALT), wait_seen};
         end
         default: begin
            next_pslverr = 1'b1;
         end
      endcase
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      pready <= setup_phase;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
   end
end

endmodule // adcc_top

// ===== bench/adcc_front.sv
// Purpose: analog front end model at the far side of the converter
// Assumes: channel 0 sits above the high reference, channel 1 below the low one
// Notes: other channels give base_code plus the channel number
`timescale 1ns/100ps
module adcc_front (
   input wire [3:0] channel_select_field,
   input wire converter_power,
   input wire [9:0] base_code,
   output logic [9:0] analog_code,
   output logic analog_over,
   output logic analog_under
);
   always_comb begin
      analog_over = converter_power && channel_select_field == 4'h0;
      analog_under = converter_power && channel_select_field == 4'h1;
      // powered down: code is not held, so show the inverse
      analog_code = converter_power ? base_code + 10'(channel_select_field) : ~base_code;
   end
endmodule // adcc_front

// ===== bench/adcc_asserts.sv
// Purpose: port checks of the conversion control
// Assumes: conversion count of 8 cycles in the bench
// Notes: bound into adcc_top
`timescale 1ns/100ps
module adcc_asserts #(
   parameter int PORT_WIDTH = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire [PORT_WIDTH-1:0] port_pins,
   input wire halt_req,
   input wire [3:0] channel_select_field,
   input wire converter_power,
   input wire sample_start
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire csr_wr = psel && penable && pwrite && paddr == 12'h000;
   chk_ready_access: assert property (psel && !penable |=> pready) else $error("no ready");
   chk_port_level: assert property (pready && !pwrite && paddr == 12'h014 |->
      prdata[PORT_WIDTH-1:0] == $past(port_pins)) else $error("port level");
   chk_on_starts: assert property (csr_wr && pwdata[5] && !converter_power && !halt_req
      |=> sample_start && channel_select_field == $past(pwdata[3:0])) else $error("no start");
   chk_chan_restart: assert property (csr_wr && pwdata[5] && converter_power && !halt_req
      && pwdata[3:0] != channel_select_field |=> sample_start) else $error("no restart");
   chk_off_stops: assert property (csr_wr && !pwdata[5] |=> !converter_power) else $error("on");
   chk_start_pulse: assert property (sample_start |=> !sample_start) else $error("pulse");
   chk_back_to_back: assert property (sample_start ##1 (!psel && !halt_req)[*7]
      |=> sample_start) else $error("no rerun");
   chk_idle_quiet: assert property (!converter_power |-> !sample_start) else $error("idle");
   chk_halt_off: assert property (halt_req[*3] |-> !converter_power) else $error("halt");
   cover property (csr_wr && pwdata[5]);
   cover property (halt_req[*3]);
   cover property (sample_start ##8 sample_start);
endmodule // adcc_asserts
bind adcc_top adcc_asserts #(.PORT_WIDTH(PORT_WIDTH)) u_chk (.*);

// ===== bench/adcc_top_tb.sv
// Purpose: self-checking bench of the conversion control
// Assumes: conversion count shortened to 8 cycles
// Notes: reads queue their expected data for the monitor
`timescale 1ns/100ps
module adcc_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, halt_req = 0, wait_req = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, converter_power, sample_start, irq, analog_over, analog_under;
   logic [9:0] analog_code, base_code = 0;
   logic [15:0] port_pins = 0;
   logic [3:0] channel_select_field;
   logic [31:0] exp_q[$];
   int miscompares = 0, cmp_count = 0, cycles = 0;
   adcc_top #(.CONV_CYCLES(8), .STAB_CYCLES(4)) DUT (.*);
   adcc_front u_front (.*);
   initial forever #4 pclk = ~pclk;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch %s exp %h seen %h", nm, want, seen);
      end
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1) @(posedge pclk);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      apb(0, a, 32'h0);
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out;
      end
      if (pready === 1 && !pwrite && exp_q.size() > 0)
         check("prdata", prdata, exp_q.pop_front());
      if (pready === 1)
         check("pslverr", {31'h0, pslverr}, {31'h0, paddr > 12'h018});
   end
   initial begin
      logic [9:0] c;
      logic [3:0] chs[3] = '{4'h0, 4'h1, 4'h9};
      void'($urandom(31388));
      repeat (8) @(posedge pclk);
      presetn <= 1;
      port_pins <= 16'($urandom);
      base_code <= 10'($urandom);
      wait_req <= 1;
      @(posedge pclk);
      rd(12'h000, 32'h0);
      rd(12'h014, {16'h0, port_pins});
      apb(1, 12'h010, 32'h1);
      for (int k = 0; k < 3; k++) begin
         apb(1, 12'h000, 32'h23);
         // changes channel while converting
         apb(1, 12'h000, {26'h0, 1'b1, 1'b0, chs[k]});
         for (int i = 0; i < 60 && irq !== 1; i++) @(posedge pclk);
         check("irq", {31'h0, irq}, 32'h1);
         apb(1, 12'h000, {28'h0, chs[k]});
         c = chs[k] == 0 ? 10'h3FF : chs[k] == 1 ? 10'h000 : base_code + 10'(chs[k]);
         rd(12'h008, {30'h0, c[1:0]});
         rd(12'h004, {24'h0, c[9:2]});
         rd(12'h000, {28'h0, chs[k]});
         apb(1, 12'h00C, 32'h1);
         repeat (2) @(posedge pclk);
         check("irq", {31'h0, irq}, 32'h0);
      end
      apb(1, 12'h010, 32'h0);
      apb(1, 12'h000, 32'h25);
      repeat (20) @(posedge pclk);
      check("irq", {31'h0, irq}, 32'h0);
      c = base_code + 10'h005;
      rd(12'h004, {24'h0, c[9:2]});
      apb(1, 12'h010, 32'h1);
      repeat (2) @(posedge pclk);
      check("irq", {31'h0, irq}, 32'h1);
      halt_req <= 1;
      repeat (4) @(posedge pclk);
      check("power", {31'h0, converter_power}, 32'h0);
      halt_req <= 0;
      rd(12'h018, 32'h7);
      rd(12'h01C, 32'h0);
      close_out;
   end
endmodule // adcc_top_tb
